/* File: psc_dev_end.sv */
// What this block does
// - seven low-speed pins incl. two serial lines
// - answer serial bus only while selected
// - host gives each module own select
// - host reads and writes map serially
// - long reset pulse restores all defaults
// - host ignores status until reset done
// - reset done: interrupt, clear not-ready flag
// - post reset-done interrupt after power-up
// - low-power input caps module power
// - presence high when absent, low fitted
// - interrupt low flags fault or status
// - host reads status to find cause
// - interrupt open drain, host pull-up
`timescale 1ns/100ps
`default_nettype none
`include "psc_params.svh"

module psc_dev_end
	import psc_pkg::*;
#(
	parameter int RST_MIN_CYC = `PSC_RST_MIN_CYC,
	parameter int INIT_CYC = `PSC_INIT_CYC,
	parameter logic [6:0] BUS_ADDR = `PSC_DEV_ADDR
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link to host
	psc_link_if.psc_dev link,
	// user side
	input wire logic fault_event,
	output logic power_cap,
	output logic module_ready
);

////////////////////////////////////////////////////////////////////////////////
	logic [4:0] s1_q;
	logic [4:0] s2_q;
	logic [4:0] pin_raw;
	logic sel_n;
	logic rstp_n;
	logic lp;
	logic scl_s;
	logic sda_s;
	logic scl_p_q;
	logic sda_p_q;
	logic start;
	logic stop;
	logic rise;
	logic fall;

	assign pin_raw = {link.module_select_n, link.module_reset_n,
		link.low_power_request, link.scl, link.sda};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_sync
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					s1_q[gi] <= 1'b1;
					s2_q[gi] <= 1'b1;
				end
				else
				begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
				end
			end
		end
	endgenerate

	assign sel_n = s2_q[4];
	assign rstp_n = s2_q[3];
	assign lp = s2_q[2];
	assign scl_s = s2_q[1];
	assign sda_s = s2_q[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
	assign rise = scl_s & ~scl_p_q;
	assign fall = ~scl_s & scl_p_q;

////////////////////////////////////////////////////////////////////////////////
	psc_rst_e rs_q, rs_d;
	logic [15:0] rcnt_q, rcnt_d;
	logic [15:0] icnt_q, icnt_d;
	logic done_evt;
	logic soft_rst;

	always_comb
	begin
		rs_d = rs_q;
		rcnt_d = rcnt_q;
		icnt_d = icnt_q;
		done_evt = 1'b0;
		if (!rstp_n)
		begin
			if (rcnt_q == 16'(RST_MIN_CYC - 1))
				rs_d = RS_HELD;
			else
				rcnt_d = rcnt_q + 16'h0001;
		end
		else
		begin
			rcnt_d = 16'h0000;
			unique case (rs_q)
				RS_HELD:
				begin
					rs_d = RS_INIT;
					icnt_d = 16'h0000;
				end
				RS_INIT:
					if (icnt_q == 16'(INIT_CYC - 1))
					begin
						rs_d = RS_READY;
						done_evt = 1'b1;
					end
					else
						icnt_d = icnt_q + 16'h0001;
				RS_READY: ;
				default: rs_d = RS_INIT;
			endcase
		end
	end

	// power-up lands in init, so completion is posted without a pulse
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rs_q <= RS_INIT;
			rcnt_q <= 16'h0000;
			icnt_q <= 16'h0000;
		end
		else
		begin
			rs_q <= rs_d;
			rcnt_q <= rcnt_d;
			icnt_q <= icnt_d;
		end
	end

	assign soft_rst = (rs_q == RS_HELD);

////////////////////////////////////////////////////////////////////////////////
	psc_byte_t mem_q [`PSC_MAP_BYTES];
	logic [1:0] flags_q, flags_d;
	psc_dst_e st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	psc_byte_t sh_q, sh_d;
	psc_byte_t tx_q, tx_d;
	logic [6:0] ptr_q, ptr_d;
	logic first_q, first_d;
	logic rw_q, rw_d;
	logic nack_q, nack_d;
	logic sda_oe_n_q, sda_oe_n_d;
	logic int_oe_n_q;
	logic cap_q;
	logic ready_q;
	logic mem_we;
	logic rd_clr;
	logic load;

	function automatic psc_byte_t map_rd(input logic [6:0] a);
		psc_byte_t v;
		v = mem_q[a];
		// not-ready flag live in status byte
		if (a == `PSC_OFS_STATUS)
			v = {6'h00, lp, rs_q != RS_READY};
		else if (a == `PSC_OFS_FLAGS)
			v = {6'h00, flags_q};
		return v;
	endfunction

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		first_d = first_q;
		rw_d = rw_q;
		nack_d = nack_q;
		mem_we = 1'b0;
		load = 1'b0;
		if (soft_rst || sel_n)
			st_d = D_IDLE;
		else if (start)
		begin
			st_d = D_ADDR;
			cnt_d = 4'h0;
		end
		else if (stop)
			st_d = D_IDLE;
		else
		begin
			unique case (st_q)
				D_IDLE: ;
				D_ADDR, D_WRITE:
					if (rise)
					begin
						sh_d = {sh_q[6:0], sda_s};
						cnt_d = cnt_q + 4'h1;
					end
					else if (fall && cnt_q == 4'h8)
					begin
						st_d = D_ACK;
						cnt_d = 4'h0;
						if (st_q == D_ADDR)
						begin
							rw_d = sh_q[0];
							first_d = ~sh_q[0];
							if (sh_q[7:1] != BUS_ADDR)
								st_d = D_IDLE;
						end
						else if (first_q)
						begin
							ptr_d = sh_q[6:0];
							first_d = 1'b0;
						end
						else
						begin
							mem_we = 1'b1;
							ptr_d = ptr_q + 7'h01;
						end
					end
				D_ACK:
					if (fall)
					begin
						cnt_d = 4'h0;
						if (rw_q)
							load = 1'b1;
						else
							st_d = D_WRITE;
					end
				D_READ:
					if (rise)
						cnt_d = cnt_q + 4'h1;
					else if (fall)
					begin
						if (cnt_q == 4'h8)
							st_d = D_RACK;
						else
							tx_d = {tx_q[6:0], 1'b0};
					end
				D_RACK:
					if (rise)
						nack_d = sda_s;
					else if (fall)
					begin
						if (nack_q)
							st_d = D_IDLE;
						else
							load = 1'b1;
					end
				default: st_d = D_IDLE;
			endcase
		end
		rd_clr = load && (ptr_q == `PSC_OFS_FLAGS);
		if (load)
		begin
			st_d = D_READ;
			cnt_d = 4'h0;
			tx_d = map_rd(ptr_q);
			ptr_d = ptr_q + 7'h01;
		end
		sda_oe_n_d = !((st_d == D_ACK) || (st_d == D_READ && !tx_d[7]));
		flags_d = soft_rst ? 2'h0 :
			((flags_q & ~{2{rd_clr}}) | {fault_event, done_evt});
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_q <= D_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= 7'h00;
			first_q <= 1'b0;
			rw_q <= 1'b0;
			nack_q <= 1'b0;
			sda_oe_n_q <= 1'b1;
			flags_q <= 2'h0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			first_q <= first_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			sda_oe_n_q <= sda_oe_n_d;
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || soft_rst)
		begin
			for (int i = 0; i < `PSC_MAP_BYTES; i++)
				mem_q[i] <= 8'h00;
			mem_q[`PSC_OFS_ID] <= `PSC_ID_VALUE;
		end
		else if (mem_we)
			mem_q[ptr_q] <= sh_q;
	end

////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			int_oe_n_q <= 1'b1;
			cap_q <= 1'b1;
			ready_q <= 1'b0;
		end
		else
		begin
			int_oe_n_q <= ~|flags_d;
			cap_q <= lp;
			ready_q <= (rs_d == RS_READY);
		end
	end

	// open drain: only ever pulls low
	assign link.int_o = 1'b0;
	assign link.int_oe_n = int_oe_n_q;
	assign link.sda_d_o = 1'b0;
	assign link.sda_d_oe_n = sda_oe_n_q;
	assign link.prs_o = 1'b0;
	assign link.prs_oe_n = 1'b0;
	assign power_cap = cap_q;
	assign module_ready = ready_q;

endmodule
`default_nettype wire

/* File: psc_host_end.sv */
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "psc_params.svh"

module psc_host_end
	import psc_pkg::*;
#(
	parameter int QTR_CYC = `PSC_SCL_QTR_CYC,
	parameter int RST_PULSE_CYC = `PSC_RST_PULSE_CYC,
	parameter logic [6:0] BUS_ADDR = `PSC_DEV_ADDR
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt
	output logic irq,
	// link to module
	psc_link_if.psc_host link
);

////////////////////////////////////////////////////////////////////////////////
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic [2:0] pin_raw;
	logic sda_s;
	logic int_s;
	logic prs_s;
	logic int_p_q;
	logic prs_p_q;

	assign pin_raw = {link.sda, link.interrupt_n, link.presence_n};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					s1_q[gi] <= 1'b1;
					s2_q[gi] <= 1'b1;
				end
				else
				begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
				end
			end
		end
	endgenerate
	assign sda_s = s2_q[2];
	assign int_s = s2_q[1];
	assign prs_s = ~s2_q[0];

////////////////////////////////////////////////////////////////////////////////
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, wmask;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, wready_q, bvalid_q, bvalid_d, arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic lp_q, lp_d, rst_pend_q, rst_pend_d, err_q, err_d;
	logic [2:0] istat_q, istat_d, imask_q, imask_d;
	logic [15:0] rpcnt_q, rpcnt_d;
	logic [16:0] cmd_q, cmd_d;
	logic wr_go, go;
	psc_hst_e hs_q, hs_d;
	logic [15:0] tcnt_q, tcnt_d;
	logic [1:0] ph_q, ph_d, byte_q, byte_d;
	logic [3:0] bit_q, bit_d;
	psc_byte_t tx_q, tx_d, rx_q, rx_d, rd_q, rd_d;
	logic sel_n_q, sel_n_d, scl_oe_n_q, scl_oe_n_d, sda_oe_n_q, sda_oe_n_d;
	logic done, nack_q, nack_d, tick;

	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_lane
			assign wmask[gi*8 +: 8] = {8{wstrb_q[gi]}};
		end
	endgenerate

	function automatic psc_byte_t tx_byte(input logic [1:0] b);
		unique case (b)
			2'h0: return {BUS_ADDR, 1'b0};
			2'h1: return cmd_q[7:0];
			2'h2: return cmd_q[16] ? {BUS_ADDR, 1'b1} : cmd_q[15:8];
			default: return 8'hff;
		endcase
	endfunction

	assign wr_go = aw_have_q & w_have_q & ~bvalid_q;
	assign tick = (tcnt_q == 16'(QTR_CYC - 1));

	always_comb
	begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q && !s_axi_bready;
		bresp_d = bresp_q;
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		lp_d = lp_q;
		imask_d = imask_q;
		cmd_d = cmd_q;
		go = 1'b0;
		rpcnt_d = (rpcnt_q != 16'h0000) ? rpcnt_q - 16'h0001 : rpcnt_q;
		rst_pend_d = rst_pend_q;
		err_d = err_q;
		istat_d = istat_q;
		if (s_axi_awvalid && awready_q)
		begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q)
		begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (wr_go)
		begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `PSC_RESP_OKAY;
			unique case (awaddr_q)
				`PSC_REG_CTRL:
				begin
					if (wstrb_q[0])
						lp_d = wdata_q[1];
					if (wstrb_q[0] && wdata_q[0] && rpcnt_q == 16'h0000)
					begin
						rpcnt_d = 16'(RST_PULSE_CYC);
						rst_pend_d = 1'b1;
					end
				end
				`PSC_REG_CMD:
					if (|wstrb_q)
					begin
						if (hs_q != H_IDLE || rst_pend_q || !prs_s)
							err_d = 1'b1;
						else
						begin
							cmd_d = (wdata_q[16:0] & wmask[16:0]);
							go = 1'b1;
							err_d = 1'b0;
						end
					end
				`PSC_REG_ISTAT:
					istat_d = istat_q & ~(wdata_q[2:0] & wmask[2:0]);
				`PSC_REG_IMASK:
					imask_d = (wdata_q[2:0] & wmask[2:0]) |
						(imask_q & ~wmask[2:0]);
				default: bresp_d = `PSC_RESP_SLVERR;
			endcase
		end
		if (s_axi_arvalid && arready_q)
		begin
			rvalid_d = 1'b1;
			arready_d = 1'b0;
			rresp_d = `PSC_RESP_OKAY;
			unique case (s_axi_araddr)
				`PSC_REG_CTRL: rdata_d = {30'h0000_0000, lp_q, rpcnt_q != 16'h0000};
				`PSC_REG_CMD: rdata_d = {15'h0000, cmd_q};
				`PSC_REG_STAT: rdata_d = {16'h0000, rd_q, 3'h0, ~int_s, prs_s,
					rst_pend_q, err_q | nack_q, hs_q != H_IDLE};
				`PSC_REG_ISTAT: rdata_d = {29'h0000_0000, istat_q};
				`PSC_REG_IMASK: rdata_d = {29'h0000_0000, imask_q};
				default:
				begin
					rdata_d = 32'h0000_0000;
					rresp_d = `PSC_RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_q && s_axi_rready)
		begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
		// completion interrupt ends the wait
		// a pulse starting this cycle must not be cleared at once
		if (rpcnt_q == 16'h0000 && rpcnt_d == 16'h0000 && !int_s)
			rst_pend_d = 1'b0;
		// interrupt edge asks software to read status
		istat_d = istat_d | {done, prs_s != prs_p_q, int_p_q & ~int_s};
	end

////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		hs_d = hs_q;
		tcnt_d = tick ? 16'h0000 : tcnt_q + 16'h0001;
		ph_d = tick ? ph_q + 2'h1 : ph_q;
		byte_d = byte_q;
		bit_d = bit_q;
		tx_d = tx_q;
		rx_d = rx_q;
		rd_d = rd_q;
		nack_d = nack_q;
		sel_n_d = sel_n_q;
		scl_oe_n_d = scl_oe_n_q;
		sda_oe_n_d = sda_oe_n_q;
		done = 1'b0;
		unique case (hs_q)
			H_IDLE:
			begin
				tcnt_d = 16'h0000;
				ph_d = 2'h0;
				if (go)
				begin
					// select this module only while talking
					sel_n_d = 1'b0;
					hs_d = H_START;
					byte_d = 2'h0;
					nack_d = 1'b0;
				end
			end
			H_START:
				if (tick)
					unique case (ph_q)
						2'h0:
						begin
							sda_oe_n_d = 1'b1;
							scl_oe_n_d = 1'b1;
						end
						2'h1: ;
						2'h2: sda_oe_n_d = 1'b0;
						2'h3:
						begin
							scl_oe_n_d = 1'b0;
							hs_d = H_BYTE;
							bit_d = 4'h0;
							tx_d = tx_byte(byte_q);
						end
					endcase
			H_BYTE:
				if (tick)
					unique case (ph_q)
						2'h0: sda_oe_n_d = (bit_q == 4'h8) | tx_q[7];
						2'h1: scl_oe_n_d = 1'b1;
						2'h2:
							if (bit_q == 4'h8)
								nack_d = sda_s & (byte_q != 2'h3);
							else
								rx_d = {rx_q[6:0], sda_s};
						2'h3:
						begin
							scl_oe_n_d = 1'b0;
							tx_d = {tx_q[6:0], 1'b1};
							bit_d = bit_q + 4'h1;
							if (bit_q == 4'h8)
							begin
								bit_d = 4'h0;
								byte_d = byte_q + 2'h1;
								tx_d = tx_byte(byte_q + 2'h1);
								if (byte_q == 2'h3)
									rd_d = rx_q;
								if (nack_q || byte_q == 2'h3 ||
									(byte_q == 2'h2 && !cmd_q[16]))
									hs_d = H_STOP;
								else if (byte_q == 2'h1 && cmd_q[16])
									hs_d = H_START;
							end
						end
					endcase
			H_STOP:
				if (tick)
					unique case (ph_q)
						2'h0: sda_oe_n_d = 1'b0;
						2'h1: scl_oe_n_d = 1'b1;
						2'h2: sda_oe_n_d = 1'b1;
						2'h3:
						begin
							hs_d = H_IDLE;
							sel_n_d = 1'b1;
							done = 1'b1;
						end
					endcase
		endcase
	end

////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= `PSC_RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= `PSC_RESP_OKAY;
			rdata_q <= 32'h0000_0000;
			lp_q <= 1'b1;
			imask_q <= 3'h0;
			istat_q <= 3'h0;
			cmd_q <= 17'h0_0000;
			rpcnt_q <= 16'h0000;
			rst_pend_q <= 1'b0;
			err_q <= 1'b0;
			int_p_q <= 1'b1;
			prs_p_q <= 1'b0;
			irq <= 1'b0;
			hs_q <= H_IDLE;
			tcnt_q <= 16'h0000;
			ph_q <= 2'h0;
			byte_q <= 2'h0;
			bit_q <= 4'h0;
			tx_q <= 8'hff;
			rx_q <= 8'h00;
			rd_q <= 8'h00;
			nack_q <= 1'b0;
			sel_n_q <= 1'b1;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
			link.module_reset_n <= 1'b1;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= ~aw_have_d;
			wready_q <= ~w_have_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			lp_q <= lp_d;
			imask_q <= imask_d;
			istat_q <= istat_d;
			cmd_q <= cmd_d;
			rpcnt_q <= rpcnt_d;
			rst_pend_q <= rst_pend_d;
			err_q <= err_d;
			int_p_q <= int_s;
			prs_p_q <= prs_s;
			irq <= |(istat_d & imask_d);
			hs_q <= hs_d;
			tcnt_q <= tcnt_d;
			ph_q <= ph_d;
			byte_q <= byte_d;
			bit_q <= bit_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			rd_q <= rd_d;
			nack_q <= nack_d;
			sel_n_q <= sel_n_d;
			scl_oe_n_q <= scl_oe_n_d;
			sda_oe_n_q <= sda_oe_n_d;
			link.module_reset_n <= (rpcnt_d == 16'h0000);
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign link.module_select_n = sel_n_q;
	assign link.low_power_request = lp_q;
	// open drain lines, never driven high
	assign link.scl_h_o = 1'b0;
	assign link.scl_h_oe_n = scl_oe_n_q;
	assign link.sda_h_o = 1'b0;
	assign link.sda_h_oe_n = sda_oe_n_q;

endmodule
`default_nettype wire

/* File: psc_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface psc_link_if;
	logic module_select_n;
	logic module_reset_n;
	logic low_power_request;
	logic scl_h_o;
	logic scl_h_oe_n;
	logic sda_h_o;
	logic sda_h_oe_n;
	logic sda_d_o;
	logic sda_d_oe_n;
	logic int_o;
	logic int_oe_n;
	logic prs_o;
	logic prs_oe_n;
	logic scl;
	logic sda;
	logic interrupt_n;
	logic presence_n;

	// open-drain wires with board pull-ups
	assign scl = scl_h_oe_n | scl_h_o;
	assign sda = (sda_h_oe_n | sda_h_o) & (sda_d_oe_n | sda_d_o);
	assign interrupt_n = int_oe_n | int_o;
	assign presence_n = prs_oe_n | prs_o;

	modport psc_dev
	(
		input module_select_n, module_reset_n, low_power_request, scl, sda,
		output sda_d_o, sda_d_oe_n, int_o, int_oe_n, prs_o, prs_oe_n
	);
	modport psc_host
	(
		output module_select_n, module_reset_n, low_power_request,
		output scl_h_o, scl_h_oe_n, sda_h_o, sda_h_oe_n,
		input sda, interrupt_n, presence_n
	);
endinterface
`default_nettype wire

/* File: psc_link_props.sv */
`timescale 1ns/100ps
`default_nettype none
module psc_link_props
#(
	parameter int RST_MIN_CYC = 20
)
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link signals
	input wire logic module_select_n,
	input wire logic module_reset_n,
	input wire logic sda_d_oe_n,
	input wire logic int_o,
	input wire logic int_oe_n,
	input wire logic scl,
	input wire logic interrupt_n,
	input wire logic presence_n
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	////////////////////////////////////////////////////////////
	// low-time count saturates so a long hold never wraps
	always_comb
	begin
		cnt_d = module_reset_n ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hff};
	end
	always_ff @(posedge aclk)
	begin
		cnt_q <= aresetn ? cnt_d : 8'h00;
	end
	////////////////////////////////////////////////////////////
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_idle_sel;
		module_select_n [*8];
	endsequence
	// margin of six covers the input synchroniser
	sequence s_long_hold;
		!module_reset_n && int'(cnt_q) >= RST_MIN_CYC + 6 ##1 module_reset_n;
	endsequence
	a_sel_gates_drive: assert property (s_idle_sel |-> sda_d_oe_n)
		else $error("data driven while deselected");
	a_int_pull_only: assert property (!int_o)
		else $error("interrupt driven high");
	a_prs_fitted: assert property (!presence_n)
		else $error("presence not low");
	a_reset_quiets: assert property ((!module_reset_n
		&& int'(cnt_q) >= RST_MIN_CYC + 6) |-> int_oe_n && sda_d_oe_n)
		else $error("device active in reset");
	a_done_posts_int: assert property (s_long_hold
		|-> ##[1:40] !interrupt_n)
		else $error("no interrupt after reset");
	a_powerup_int: assert property ($rose(aresetn)
		|-> ##[1:40] !interrupt_n)
		else $error("no interrupt after power-up");
	a_sda_scl_low: assert property ($changed(sda_d_oe_n) |-> !scl)
		else $error("data moved while clock high");
	a_scl_needs_sel: assert property ($fell(scl)
		|-> !module_select_n)
		else $error("clock toggled while deselected");
endmodule
`default_nettype wire

/* File: psc_params.svh */
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

// clock and derived timing
`define PSC_CLK_MHZ 20
`define PSC_SCL_QTR_NS 2500
`define PSC_SCL_QTR_CYC ((`PSC_SCL_QTR_NS * `PSC_CLK_MHZ) / 1000)
`define PSC_RST_MIN_NS 10000
`define PSC_RST_MIN_CYC ((`PSC_RST_MIN_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_RST_PULSE_NS 20000
`define PSC_RST_PULSE_CYC ((`PSC_RST_PULSE_NS * `PSC_CLK_MHZ + 999) / 1000)
`define PSC_INIT_NS 1000
`define PSC_INIT_CYC ((`PSC_INIT_NS * `PSC_CLK_MHZ + 999) / 1000)

// module memory map
`define PSC_DEV_ADDR 7'h50
`define PSC_MAP_BYTES 128
`define PSC_OFS_ID 7'h00
`define PSC_OFS_STATUS 7'h02
`define PSC_OFS_FLAGS 7'h03
// arbitrary identification value
`define PSC_ID_VALUE 8'h5a

// controller registers
`define PSC_REG_CTRL 8'h00
`define PSC_REG_CMD 8'h04
`define PSC_REG_STAT 8'h08
`define PSC_REG_ISTAT 8'h0c
`define PSC_REG_IMASK 8'h10
`define PSC_RESP_OKAY 2'h0
`define PSC_RESP_SLVERR 2'h2

`endif

/* File: psc_pkg.sv */
package psc_pkg;

	typedef logic [7:0] psc_byte_t;

	typedef enum logic [2:0]
	{
		D_IDLE = 3'b000,
		D_ADDR = 3'b001,
		D_ACK = 3'b010,
		D_WRITE = 3'b011,
		D_READ = 3'b100,
		D_RACK = 3'b101
	} psc_dst_e;

	typedef enum logic [1:0]
	{
		RS_INIT = 2'b00,
		RS_HELD = 2'b01,
		RS_READY = 2'b10
	} psc_rst_e;

	typedef enum logic [1:0]
	{
		H_IDLE = 2'b00,
		H_START = 2'b01,
		H_BYTE = 2'b10,
		H_STOP = 2'b11
	} psc_hst_e;

endpackage

/* File: psc_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "psc_params.svh"
module psc_tb_top;
	logic aclk, aresetn, fault_event, power_cap, module_ready, irq;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rdat;
	logic [1:0] bresp, rresp, resp;
	logic [3:0] wstrb;
	int failures, cmp_count;
	psc_link_if link();
	psc_host_end #(.QTR_CYC(4), .RST_PULSE_CYC(40)) i_psc_host_end
	(
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .link(link)
	);
	psc_dev_end #(.RST_MIN_CYC(20), .INIT_CYC(5)) i_psc_dev_end
	(
		.aclk(aclk), .aresetn(aresetn), .link(link), .fault_event(fault_event),
		.power_cap(power_cap), .module_ready(module_ready)
	);
	psc_link_props #(.RST_MIN_CYC(20)) i_props
	(
		.aclk(aclk), .aresetn(aresetn), .module_select_n(link.module_select_n),
		.module_reset_n(link.module_reset_n), .sda_d_oe_n(link.sda_d_oe_n),
		.int_o(link.int_o), .int_oe_n(link.int_oe_n), .scl(link.scl),
		.interrupt_n(link.interrupt_n), .presence_n(link.presence_n)
	);
	////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wrap_up;
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			resp = bresp;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			rdat = rdata;
			resp = rresp;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask
	// wait while a status bit is set, bounded; running out is a mismatch
	task poll(input int b);
		rd(`PSC_REG_STAT);
		repeat (300)
			if (rdat[b] !== 1'b0)
				rd(`PSC_REG_STAT);
		chk(32'(rdat[b]), 32'h0);
	endtask
	task mrd(input logic [7:0] ofs, input logic [7:0] exp);
		wr(`PSC_REG_CMD, {15'h0, 1'b1, 8'h00, ofs});
		poll(0);
		chk({23'h0, rdat[15:8], rdat[1]}, {23'h0, exp, 1'b0});
	endtask
	task step(input int n);
		repeat (n) @(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////
	task t_powerup;
		step(30);
		chk(32'(module_ready), 32'h1);
		rd(`PSC_REG_STAT);
		chk(32'(rdat[4:3]), 32'h3);
		chk(32'(power_cap), 32'h1);
	endtask
	task t_map;
		mrd(`PSC_OFS_ID, `PSC_ID_VALUE);
		mrd(`PSC_OFS_FLAGS, 8'h01);
		rd(`PSC_REG_STAT);
		chk(32'(rdat[4]), 32'h0);
	endtask
	task t_fault;
		wr(`PSC_REG_ISTAT, 32'h7);
		fault_event <= 1'b1;
		step(1);
		fault_event <= 1'b0;
		step(8);
		chk(32'(irq), 32'h0);
		wr(`PSC_REG_IMASK, 32'h1);
		step(2);
		chk(32'(irq), 32'h1);
		wr(`PSC_REG_ISTAT, 32'h1);
		step(2);
		chk(32'(irq), 32'h0);
		mrd(`PSC_OFS_FLAGS, 8'h02);
	endtask
	// lane zero strobe off: the control write must leave power alone
	task t_lowpow;
		wstrb <= 4'he;
		wr(`PSC_REG_CTRL, 32'h0);
		step(6);
		chk(32'(power_cap), 32'h1);
		wstrb <= 4'hf;
		wr(`PSC_REG_CTRL, 32'h0);
		step(6);
		chk(32'(power_cap), 32'h0);
		mrd(`PSC_OFS_STATUS, 8'h00);
		wr(`PSC_REG_CTRL, 32'h2);
		step(6);
		chk(32'(power_cap), 32'h1);
	endtask
	task t_modreset;
		wr(`PSC_REG_CMD, {15'h0, 1'b0, 8'ha5, 8'h10});
		poll(0);
		mrd(8'h10, 8'ha5);
		wr(`PSC_REG_CTRL, 32'h3);
		wr(`PSC_REG_CMD, 32'h1_0000);
		rd(`PSC_REG_STAT);
		chk(32'(rdat[2:0]), 32'h6);
		poll(2);
		step(10);
		mrd(`PSC_OFS_STATUS, 8'h02);
		mrd(`PSC_OFS_FLAGS, 8'h01);
		mrd(8'h10, 8'h00);
	endtask
	// refused requests: unmapped places and a command while busy
	task t_refuse;
		rd(8'h20);
		chk(rdat, 32'h0);
		chk(32'(resp), 32'h2);
		wr(8'h24, 32'h1);
		chk(32'(resp), 32'h2);
		wr(`PSC_REG_CMD, 32'h1_0000);
		wr(`PSC_REG_CMD, 32'h1_0000);
		rd(`PSC_REG_STAT);
		chk(32'(rdat[1:0]), 32'h3);
		poll(0);
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial
	begin
		{aresetn, fault_event, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		step(10);
		aresetn <= 1'b1;
		t_powerup();
		t_map();
		t_fault();
		t_lowpow();
		t_modreset();
		t_refuse();
		wrap_up();
	end
	// the run needs well under ten thousand cycles
	initial
	begin
		#(50 * 20000);
		failures++;
		wrap_up();
	end
endmodule
`default_nettype wire
